// ==== rtl/mcb_pkg.sv ====
// constants and types shared by the monitor register bank
package mcb_pkg;

	// ************************************************************
	// register pointer values
	// ************************************************************
	localparam logic [7:0] PTR_CONFIG = 8'h00;
	localparam logic [7:0] PTR_SHUNT = 8'h01;
	localparam logic [7:0] PTR_BUS = 8'h02;
	localparam logic [7:0] PTR_POWER = 8'h03;
	localparam logic [7:0] PTR_CURRENT = 8'h04;
	localparam logic [7:0] PTR_SCALE = 8'h05;
	localparam logic [7:0] PTR_ALERT_ME = 8'h06;
	localparam logic [7:0] PTR_ALERT_LIM = 8'h07;
	localparam logic [7:0] PTR_MAKER = 8'h3E;
	localparam logic [7:0] PTR_PART = 8'h3F;

	// ************************************************************
	// reset values and write masks
	// ************************************************************
	localparam logic [15:0] CONFIG_RST = 16'h4127;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [15:0] RESERVED_READ = 16'h0000;
	localparam logic [15:0] REG_RST [8] = '{CONFIG_RST, RESULT_RST,
		RESULT_RST, RESULT_RST, RESULT_RST, RESULT_RST, RESULT_RST,
		RESULT_RST};
	localparam logic [15:0] CFG_WR_MASK = 16'h1FFF;
	localparam logic [15:0] FULL_WR_MASK = 16'hFFFF;
	localparam logic [15:0] NO_WR_MASK = 16'h0000;
	localparam logic [1:0] CFG_FIXED = 2'b10;

	// ************************************************************
	// configuration field positions
	// ************************************************************
	localparam int CFG_SRST_BIT = 15;
	localparam int CFG_FIXED_LSB = 13;
	localparam int CFG_RANGE_BIT = 12;
	localparam int CFG_AVG_LSB = 9;
	localparam int CFG_BUSCT_LSB = 6;
	localparam int CFG_SHCT_LSB = 3;
	localparam int CFG_MODE_LSB = 0;

	// ************************************************************
	// timing and averaging tables
	// ************************************************************
	localparam int unsigned MCLK_MHZ = 40;
	localparam int unsigned CONV_US [8] = '{140, 204, 332, 588, 1100,
		2116, 4156, 8244};
	localparam int unsigned AVG_N [8] = '{1, 4, 16, 64, 128, 256, 512,
		1024};
	localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic srst;
		logic [1:0] fixed;
		logic shunt_range_select;
		logic [2:0] average_count;
		logic [2:0] bus_conv_time;
		logic [2:0] shunt_conv_time;
		logic [2:0] mode;
	} mcb_cfg_type;

	typedef struct packed {
		logic xfer_start;
		logic ptr_we;
		logic wr_we;
		logic rd_re;
		logic [7:0] data;
	} mcb_req_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHUNT = 2'b01,
		ST_BUS = 2'b11
	} mcb_state_type;

endpackage

// ==== rtl/mcb_monitor_regs.sv ====
// register bank and conversion sequencer of the power monitor
// How it works
// [R1] eight 16-bit registers at 0h-7h plus identity words at 3Eh, 3Fh
// [R2] host leaves unlisted offsets alone; they read zero, writes dropped
// [R3] configuration holds 4127h after power-on or any reset
// [R4] writing one to configuration bit 15 resets every register; reads 0
// [R5] configuration bits 14-13 are fixed and read 10b
// [R6] bit 12 picks shunt range; 0 is 81.92 mV and the reset value
// [R7] bits 11-9 pick 1 to 1024 averaged samples; reset 000b
// [R8] result registers change only when averaging completes
// [R9] bits 8-6 set bus conversion time; reset 100b; 000b is 140 us
// [R10] codes 001b-111b give 204 up to 8244 us conversion time
// [R11] mode bits 2-0: shutdown, single shot or continuous; reset 111b
// [R12] each register moves as two bytes, high byte first
// [R13] writes to read-only bits are ignored; fixed values stay
`timescale 1ns/1ps
module mcb_monitor_regs
	import mcb_pkg::*;
#(
	parameter int unsigned CYC_PER_US = MCLK_MHZ,
	parameter logic [15:0] MAKER_CODE = 16'h1357, // arbitrary value
	parameter logic [15:0] PART_CODE = 16'h2468 // arbitrary value
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// byte port from the serial engine
	input wire mcb_req_type host_req_i,
	output logic [7:0] rd_byte_o,
	output logic rd_valid_o,
	// analogue converter words, foreign timing
	input wire logic [15:0] raw_shunt_i,
	input wire logic [15:0] raw_bus_i,
	// derived current and power from local logic
	input wire logic [15:0] cur_calc_i,
	input wire logic [15:0] pow_calc_i,
	// configuration and status toward the rest of the chip
	output logic shunt_range_o,
	output logic [1:0] conv_sel_o,
	output logic result_update_o,
	output logic [15:0] scale_factor_o,
	output logic [15:0] alert_mask_o,
	output logic [15:0] alert_threshold_o
);

	// ************************************************************
	// helpers
	// ************************************************************
	// cycles of one conversion, minus the cycle of loading
	function automatic logic [19:0] conv_load(input logic [2:0] code);
		conv_load = 20'(CONV_US[code] * CYC_PER_US - 1);
	endfunction
	function automatic logic [9:0] last_smp(input logic [2:0] code);
		last_smp = 10'(AVG_N[code] - 1);
	endfunction
	function automatic logic [15:0] wr_mask(input logic [2:0] idx);
		case (idx)
			3'h0: wr_mask = CFG_WR_MASK;
			3'h5, 3'h6, 3'h7: wr_mask = FULL_WR_MASK;
			default: wr_mask = NO_WR_MASK;
		endcase
	endfunction
	function automatic mcb_state_type start_st(input mcb_cfg_type c);
		start_st = c.mode[0] ? ST_SHUNT : (c.mode[1] ? ST_BUS : ST_IDLE);
	endfunction
	function automatic logic [19:0] start_cnt(input mcb_cfg_type c);
		start_cnt = c.mode[0] ? conv_load(c.shunt_conv_time) :
			conv_load(c.bus_conv_time);
	endfunction
	localparam logic [19:0] RST_CNT =
		20'(CONV_US[CONFIG_RST[CFG_SHCT_LSB+:3]] * CYC_PER_US - 1);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [15:0] sh_meta_q, sh_sync_q, bus_meta_q, bus_sync_q;

	// converter words come from the analogue side, so two stages
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sh_meta_q <= 16'h0000;
			sh_sync_q <= 16'h0000;
			bus_meta_q <= 16'h0000;
			bus_sync_q <= 16'h0000;
		end else begin
			sh_meta_q <= raw_shunt_i;
			sh_sync_q <= sh_meta_q;
			bus_meta_q <= raw_bus_i;
			bus_sync_q <= bus_meta_q;
		end
	end

	// ************************************************************
	// register file, byte port and sequencer state
	// ************************************************************
	logic [15:0] regs_q [8];
	logic [15:0] regs_d [8];
	logic [7:0] ptr_q, ptr_d, msb_q, msb_d, rd_byte_q, rd_byte_d;
	logic phase_q, phase_d, rd_valid_q, rd_valid_d, upd_q, upd_d;
	logic [15:0] shadow_q, shadow_d, rd_word, wdata, wmask, wr_val;
	mcb_state_type st_q, st_d;
	logic [19:0] cnt_q, cnt_d;
	logic [9:0] smp_q, smp_d;
	logic signed [25:0] acc_sh_q, acc_sh_d, sh_sum;
	logic [25:0] acc_bus_q, acc_bus_d, bus_sum;
	logic [1:0] sel_q, sel_d;
	logic fin, srst;
	mcb_cfg_type cfg, new_cfg;

	assign cfg = mcb_cfg_type'(regs_q[0]);
	assign wdata = {msb_q, host_req_i.data};
	assign wmask = wr_mask(ptr_q[2:0]);
	assign wr_val = (regs_q[ptr_q[2:0]] & ~wmask) | (wdata & wmask); // R13
	assign new_cfg = mcb_cfg_type'(wr_val);

	// read mux; unlisted offsets return zero
	always_comb begin
		if (ptr_q <= PTR_ALERT_LIM)
			rd_word = regs_q[ptr_q[2:0]]; // R1
		else if (ptr_q == PTR_MAKER)
			rd_word = MAKER_CODE; // R1
		else if (ptr_q == PTR_PART)
			rd_word = PART_CODE;
		else
			rd_word = RESERVED_READ;
	end

	// next state of everything; host writes override the sequencer
	always_comb begin
		regs_d = regs_q;
		ptr_d = ptr_q;
		msb_d = msb_q;
		phase_d = phase_q;
		shadow_d = shadow_q;
		rd_byte_d = rd_byte_q;
		rd_valid_d = 1'b0;
		st_d = st_q;
		cnt_d = cnt_q;
		smp_d = smp_q;
		acc_sh_d = acc_sh_q;
		acc_bus_d = acc_bus_q;
		sh_sum = acc_sh_q;
		bus_sum = acc_bus_q;
		upd_d = 1'b0;
		fin = 1'b0;
		srst = 1'b0;
		// conversion timing per phase
		if (st_q != ST_IDLE) begin
			if (cnt_q != 20'h00000) begin
				cnt_d = cnt_q - 20'h00001; // R9 R10
			end else if (st_q == ST_SHUNT) begin
				sh_sum = acc_sh_q + {{10{sh_sync_q[15]}}, sh_sync_q};
				acc_sh_d = sh_sum;
				if (cfg.mode[1]) begin
					st_d = ST_BUS;
					cnt_d = conv_load(cfg.bus_conv_time); // R9 R10
				end else begin
					fin = 1'b1;
				end
			end else begin
				bus_sum = acc_bus_q + {10'h000, bus_sync_q};
				acc_bus_d = bus_sum;
				fin = 1'b1;
			end
		end
		// one sample set done; publish only after the last one
		if (fin) begin
			if (smp_q == last_smp(cfg.average_count)) begin // R7
				if (cfg.mode[0])
					regs_d[1] = 16'(sh_sum >>> AVG_SHIFT[cfg.average_count]);
				if (cfg.mode[1])
					regs_d[2] = 16'(bus_sum >> AVG_SHIFT[cfg.average_count]);
				regs_d[3] = pow_calc_i;
				regs_d[4] = cur_calc_i;
				upd_d = 1'b1; // R8
				smp_d = 10'h000;
				acc_sh_d = 26'h0000000;
				acc_bus_d = 26'h0000000;
				// single shot stops, continuous goes round again
				st_d = cfg.mode[2] ? start_st(cfg) : ST_IDLE; // R11
			end else begin
				smp_d = smp_q + 10'h001;
				st_d = start_st(cfg);
			end
			cnt_d = start_cnt(cfg);
		end
		// byte port; start or pointer write realigns to the high byte
		if (host_req_i.xfer_start)
			phase_d = 1'b0;
		if (host_req_i.ptr_we) begin
			ptr_d = host_req_i.data;
			phase_d = 1'b0;
		end else if (host_req_i.wr_we) begin
			if (!phase_q) begin
				msb_d = host_req_i.data; // R12
				phase_d = 1'b1;
			end else begin
				phase_d = 1'b0;
				if (ptr_q == PTR_CONFIG && wdata[CFG_SRST_BIT]) begin
					srst = 1'b1; // R4
				end else if (ptr_q <= PTR_ALERT_LIM) begin
					regs_d[ptr_q[2:0]] = wr_val; // R5 R6 R13
					if (ptr_q == PTR_CONFIG) begin
						// a new setting restarts the measurement
						st_d = start_st(new_cfg); // R11
						cnt_d = start_cnt(new_cfg);
						smp_d = 10'h000;
						acc_sh_d = 26'h0000000;
						acc_bus_d = 26'h0000000;
					end
				end
			end
		end else if (host_req_i.rd_re) begin
			rd_valid_d = 1'b1;
			// low byte comes from a snapshot, so the word is coherent
			if (!phase_q) begin
				shadow_d = rd_word;
				rd_byte_d = rd_word[15:8]; // R12
				phase_d = 1'b1;
			end else begin
				rd_byte_d = shadow_q[7:0];
				phase_d = 1'b0;
			end
		end
		// soft reset behaves as power-on for the register set
		if (srst) begin
			regs_d = REG_RST; // R3 R4
			st_d = ST_SHUNT;
			cnt_d = RST_CNT;
			smp_d = 10'h000;
			acc_sh_d = 26'h0000000;
			acc_bus_d = 26'h0000000;
			upd_d = 1'b0;
		end
		sel_d = {st_d == ST_BUS, st_d == ST_SHUNT};
	end

	// register the whole state
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			regs_q <= REG_RST; // R3
			ptr_q <= PTR_CONFIG;
			msb_q <= 8'h00;
			phase_q <= 1'b0;
			shadow_q <= 16'h0000;
			rd_byte_q <= 8'h00;
			rd_valid_q <= 1'b0;
			st_q <= ST_SHUNT;
			cnt_q <= RST_CNT;
			smp_q <= 10'h000;
			acc_sh_q <= 26'h0000000;
			acc_bus_q <= 26'h0000000;
			upd_q <= 1'b0;
			sel_q <= 2'b01;
		end else begin
			regs_q <= regs_d;
			ptr_q <= ptr_d;
			msb_q <= msb_d;
			phase_q <= phase_d;
			shadow_q <= shadow_d;
			rd_byte_q <= rd_byte_d;
			rd_valid_q <= rd_valid_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			smp_q <= smp_d;
			acc_sh_q <= acc_sh_d;
			acc_bus_q <= acc_bus_d;
			upd_q <= upd_d;
			sel_q <= sel_d;
		end
	end

	// ************************************************************
	// outputs, all straight from flip-flops
	// ************************************************************
	assign rd_byte_o = rd_byte_q;
	assign rd_valid_o = rd_valid_q;
	assign shunt_range_o = regs_q[0][CFG_RANGE_BIT]; // R6
	assign conv_sel_o = sel_q;
	assign result_update_o = upd_q;
	assign scale_factor_o = regs_q[5];
	assign alert_mask_o = regs_q[6];
	assign alert_threshold_o = regs_q[7];

	// ************************************************************
	// assertions
	// ************************************************************
	sequence lsb_wr_s(logic [7:0] p);
		host_req_i.wr_we && !host_req_i.ptr_we && phase_q && ptr_q == p;
	endsequence
	sequence srst_wr_s;
		lsb_wr_s(PTR_CONFIG) ##0 msb_q[7];
	endsequence
	sequence rd_byte_s(logic ph);
		host_req_i.rd_re && !host_req_i.ptr_we && !host_req_i.wr_we &&
		!host_req_i.xfer_start && phase_q == ph;
	endsequence

	soft_reset_val_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		srst_wr_s |=> regs_q[0] == CONFIG_RST && regs_q[5] == RESULT_RST) // R3
		else $error("soft reset did not restore defaults");
	srst_regs_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		srst_wr_s |=> regs_q[7] == RESULT_RST && !regs_q[0][CFG_SRST_BIT]) // R4
		else $error("soft reset left a register or bit 15 set");
	fixed_bits_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		regs_q[0][CFG_FIXED_LSB+:2] == CFG_FIXED) // R5
		else $error("fixed configuration bits changed");
	range_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		lsb_wr_s(PTR_CONFIG) ##0 !msb_q[7] |=>
		shunt_range_o == $past(msb_q[4])) // R6
		else $error("range bit not taken from write");
	avg_count_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		result_update_o |->
		$past(smp_q) == last_smp($past(cfg.average_count))) // R7
		else $error("results published before all samples");
	result_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$changed(regs_q[2]) && !$past(srst) |-> result_update_o) // R8
		else $error("result changed without completed average");
	bus_time_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		st_q == ST_BUS && $past(st_q) == ST_SHUNT |->
		cnt_q == conv_load(cfg.bus_conv_time)) // R9
		else $error("bus conversion time loaded wrongly");
	shutdown_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		cfg.mode[1:0] == 2'b00 |-> st_q == ST_IDLE) // R11
		else $error("converting in shutdown mode");
	read_order_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd_byte_s(1'b0) |=>
		rd_valid_o && rd_byte_o == $past(rd_word[15:8])) // R12
		else $error("high byte not first on read");
	read_low_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd_byte_s(1'b1) |=>
		rd_valid_o && rd_byte_o == $past(shadow_q[7:0])) // R12
		else $error("low byte not from the captured word");
	maker_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd_byte_s(1'b0) ##0 ptr_q == PTR_MAKER |=>
		rd_byte_o == MAKER_CODE[15:8]) // R1
		else $error("identity word read wrong");

endmodule

// ==== test/mcb_host_model.sv ====
// host controller model driving the register byte port
`timescale 1ns/1ps
module mcb_host_model
	import mcb_pkg::*;
(
	// clock
	input wire logic mclk_i,
	// answers from the bank
	input wire logic [7:0] rd_byte_i,
	input wire logic rd_valid_i,
	// byte requests
	output mcb_req_type host_req_o
);
	// ************************************************************
	// byte strobes
	// ************************************************************
	initial host_req_o = '0;

	// one strobe a call; released data is inverted so it never looks held
	task automatic strobe(input logic [2:0] k, input logic [7:0] d,
		output logic [7:0] b, output logic v);
		@(negedge mclk_i);
		host_req_o = {k[2], k, d};
		@(negedge mclk_i);
		b = rd_byte_i;
		v = rd_valid_i;
		host_req_o = {4'h0, ~d};
	endtask

	// pointer load also marks a fresh transfer
	task automatic put_ptr(input logic [7:0] p);
		logic [7:0] b;
		logic v;
		strobe(3'b100, p, b, v);
	endtask

	// words go high byte first in both directions
	task automatic put_word(input logic [15:0] w);
		logic [7:0] b;
		logic v;
		strobe(3'b010, w[15:8], b, v);
		strobe(3'b010, w[7:0], b, v);
	endtask

	task automatic get_word(output logic [15:0] w, output logic ok);
		logic v0;
		logic v1;
		strobe(3'b001, 8'h00, w[15:8], v0);
		strobe(3'b001, 8'h00, w[7:0], v1);
		ok = v0 & v1;
	endtask
endmodule

// ==== test/test_monitor_config_register_bank.sv ====
// self-checking bench of the monitor register bank
`timescale 1ns/1ps
module test_monitor_config_register_bank
	import mcb_pkg::*;
;
	localparam logic [15:0] MAKER = 16'h1357; // arbitrary value
	localparam logic [15:0] PART = 16'h2468; // arbitrary value
	typedef struct packed {
		logic [7:0] ptr;
		logic wr;
		logic [15:0] wd;
		logic [15:0] exp;
	} mcb_row_type;

	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	mcb_req_type host_req;
	logic [7:0] rd_byte;
	logic rd_valid;
	logic [15:0] raw_shunt = 16'h0100;
	logic [15:0] raw_bus = 16'h0200;
	logic [15:0] cur_calc = 16'h0C0C;
	logic [15:0] pow_calc = 16'h0D0D;
	logic shunt_range;
	logic [1:0] conv_sel;
	logic result_update;
	logic [15:0] scale;
	logic [15:0] mask;
	logic [15:0] thr;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;

	// ************************************************************
	// clock, instances, watchdog
	// ************************************************************
	always #12.5 mclk_i = ~mclk_i;

	mcb_monitor_regs #(.CYC_PER_US(1), .MAKER_CODE(MAKER),
		.PART_CODE(PART)) mcb_monitor_regs_inst (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .host_req_i(host_req),
		.rd_byte_o(rd_byte), .rd_valid_o(rd_valid),
		.raw_shunt_i(raw_shunt), .raw_bus_i(raw_bus),
		.cur_calc_i(cur_calc), .pow_calc_i(pow_calc),
		.shunt_range_o(shunt_range), .conv_sel_o(conv_sel),
		.result_update_o(result_update), .scale_factor_o(scale),
		.alert_mask_o(mask), .alert_threshold_o(thr));

	mcb_host_model mcb_host_model_inst (.mclk_i(mclk_i),
		.rd_byte_i(rd_byte), .rd_valid_i(rd_valid),
		.host_req_o(host_req));

	// the whole run needs about 2000 cycles; a hang stops at 5000
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			finish_test();
		end
	end

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] p, input logic [15:0] exp);
		logic [15:0] w;
		logic ok;
		mcb_host_model_inst.put_ptr(p);
		mcb_host_model_inst.get_word(w, ok);
		check(ok, 1'b1);
		check(w, exp);
	endtask

	// write config, then count cycles to the result pulse
	task automatic run(input logic [15:0] cfg, output int cnt);
		mcb_host_model_inst.put_ptr(8'h00);
		mcb_host_model_inst.put_word(cfg);
		cnt = 0;
		while (result_update !== 1'b1 && cnt < 3000) begin
			@(posedge mclk_i);
			#1;
			cnt++;
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ************************************************************
	// ordinary cases: pointer, optional write, expected read
	// ************************************************************
	mcb_row_type rows [22] = '{
		'{8'h00, 1'b0, 16'h0000, 16'h4127}, '{8'h01, 1'b0, 16'h0000, 16'h0000},
		'{8'h02, 1'b0, 16'h0000, 16'h0000}, '{8'h03, 1'b0, 16'h0000, 16'h0000},
		'{8'h04, 1'b0, 16'h0000, 16'h0000}, '{8'h05, 1'b0, 16'h0000, 16'h0000},
		'{8'h06, 1'b0, 16'h0000, 16'h0000}, '{8'h07, 1'b0, 16'h0000, 16'h0000},
		'{8'h3E, 1'b0, 16'h0000, MAKER}, '{8'h3F, 1'b0, 16'h0000, PART},
		'{8'h08, 1'b0, 16'h0000, 16'h0000}, '{8'h3D, 1'b0, 16'h0000, 16'h0000},
		'{8'h05, 1'b1, 16'h1234, 16'h1234}, '{8'h06, 1'b1, 16'hA5C3, 16'hA5C3},
		'{8'h07, 1'b1, 16'hFFFF, 16'hFFFF}, '{8'h01, 1'b1, 16'hFFFF, 16'h0000},
		'{8'h04, 1'b1, 16'h00FF, 16'h0000}, '{8'h3E, 1'b1, 16'h0000, MAKER},
		'{8'h3F, 1'b1, 16'hFFFF, PART}, '{8'h7F, 1'b0, 16'h0000, 16'h0000},
		'{8'h40, 1'b0, 16'h0000, 16'h0000}, '{8'h00, 1'b1, 16'h7FF8, 16'h5FF8}};
	int unsigned tab [3] = '{140, 204, 332};

	initial begin
		repeat (5) @(negedge mclk_i);
		rstn_i = 1'b1;
		check(conv_sel, 2'b01);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				mcb_host_model_inst.put_ptr(rows[i].ptr);
				mcb_host_model_inst.put_word(rows[i].wd);
			end
			rd(rows[i].ptr, rows[i].exp);
		end
		check(shunt_range, 1'b1);
		check(conv_sel, 2'b00);
		check(scale, 16'h1234);
		check(mask, 16'hA5C3);
		check(thr, 16'hFFFF);

		// soft reset returns configuration and scale factor to their reset values and clears the bit itself
		mcb_host_model_inst.put_word(16'h8000);
		rd(8'h00, 16'h4127);
		check(scale, 16'h0000);
		check(shunt_range, 1'b0);
		check(conv_sel, 2'b01);

		// single shunt shot with no averaging, 140 cycles
		run(16'h4001, n);
		check(16'(n >= 137 && n <= 146), 16'h0001);
		rd(8'h01, 16'h0100);
		rd(8'h02, 16'h0000);
		rd(8'h03, 16'h0D0D);
		rd(8'h04, 16'h0C0C);
		check(conv_sel, 2'b00);

		// bus conversion time codes
		for (int c = 0; c < 3; c++) begin
			run(16'h0002 | 16'(c << 6), n);
			check(16'(n + 3 >= tab[c] && n <= tab[c] + 6), 16'h0001);
		end
		rd(8'h02, 16'h0200);

		// continuous shunt then bus, restarting with shunt after publish
		raw_bus = 16'h0280;
		run(16'h0007, n);
		check(16'(n >= 277 && n <= 286), 16'h0001);
		check(conv_sel, 2'b01);
		rd(8'h02, 16'h0280);

		// four averaged bus samples publish once, after all four
		raw_bus = 16'h0300;
		run(16'h0202, n);
		check(16'(n >= 557 && n <= 566), 16'h0001);
		rd(8'h02, 16'h0300);

		// pin reset with the sequencer idle brings scale factor and configuration back
		mcb_host_model_inst.put_ptr(8'h05);
		mcb_host_model_inst.put_word(16'h55AA);
		check(scale, 16'h55AA);
		@(negedge mclk_i);
		rstn_i = 1'b0;
		@(negedge mclk_i);
		check(rd_valid, 1'b0);
		rstn_i = 1'b1;
		check(scale, 16'h0000);
		rd(8'h00, 16'h4127);
		finish_test();
	end
endmodule
